/* File: design/bcpa_map.svh */
// bcpa_map.svh: offsets, field positions and reset values of the port block
// assumes byte addresses on a 32-bit apb word bus
`ifndef BCPA_MAP_SVH
`define BCPA_MAP_SVH
// register indexes, byte address is index times four
`define BCPA_IDX_LOW_DATA     8'h01
`define BCPA_IDX_CTL_DATA     8'h08
`define BCPA_IDX_CTL_DIR      8'h09
`define BCPA_IDX_ASSIGN       8'h0a
`define BCPA_IDX_MODE         8'h0b
`define BCPA_IDX_LOW_DIR      8'h03
`define BCPA_IDX_PULL         8'h0c
// assignment register fields
`define BCPA_NO_DATA_ENABLE_BIT         7
`define BCPA_CLOCK_GEN_TEST_ENABLE_BIT        6
`define BCPA_PIPE_OUTPUT_ENABLE_BIT        5
`define BCPA_NO_E_CLOCK_BIT        4
`define BCPA_LOW_STROBE_ENABLE_BIT        3
`define BCPA_READ_WRITE_ENABLE_BIT         2
`define BCPA_CALIBRATION_ENABLE_BIT         1
`define BCPA_DATA_ENABLE_SELECT_BIT        0
// write-once assignment bits (all but calibration enable)
`define BCPA_ONCE_MASK        8'hfd
// assignment reset values per mode
`define BCPA_RST_NORM_EXP     8'h00
`define BCPA_RST_SPEC         8'h2c
`define BCPA_RST_PERIPH       8'hd0
`define BCPA_RST_NORM_SC      8'h90
// mode register fields of our own register
`define BCPA_EME_BIT          0
`define BCPA_E_STRETCH_BIT         1
// mode register bits that exist
`define BCPA_MODE_MASK        8'h03
// direction bits that exist on the control port
`define BCPA_CTL_DIR_MASK     8'hfc
// pull-up bit position in the pull register
`define BCPA_PUPE_BIT         4
`define BCPA_PULL_RST         8'h10
// control pins that carry a pull-up: 7, 3, 2, 1 and 0
`define BCPA_PULL_PINS        8'h8f
// bits of the byte lanes within a word
`define BCPA_LANE0_MSB        7
`define BCPA_LANE1_LSB        8
`define BCPA_LANE1_MSB        15
`endif

/* File: design/bcpa_pkg.sv */
// bcpa_pkg.sv: types of the bus control port assignment block
// assumes nothing beyond a standard sv compiler
package bcpa_pkg;
  // operating modes strapped by the mode select pins
  typedef enum logic [2:0] {
    BCPA_NORM_SC,
    BCPA_NORM_EXP_NARROW,
    BCPA_NORM_EXP_WIDE,
    BCPA_PERIPH,
    BCPA_SPEC_SC,
    BCPA_SPEC_EXP_NARROW,
    BCPA_SPEC_EXP_WIDE
  } bcpa_mode_t;
endpackage

/* File: design/bcpa_port.sv */
// bcpa_port.sv: low port and control port pin logic with apb registers
// assumes a 125 mhz core clock, async high reset, mode fixed from reset
//
// How it works
// - expanded wide/periph: low pins multiplex address, data
// - single chip: low pins are direction-steered gpio; expanded narrow: address only
// - low data register leaves map when expanded
// - control pins gpio unless assignment selects alternate
// - control data/dir leave map: periph, emulate
// - direction 0 input, 1 output; bits 7..2
// - interrupt pins never outputs, always readable
// - one pull bit for strobe-type input pins
// - alternate selection overrides direction bit
// - normal single chip resets all gpio
// - normal expanded resets data enable, e clock only
// - special expanded modes reset bus control functions active
// - peripheral: assignment hidden, clock test set
// - no-data-enable picks pin 7 function
// - write-once normal, skip-first special
// - clock test bit: never in normal, routing
// - pipe enable puts queue status on 6,5
// - no-e-clock write rules per mode
// - e clock input in peripheral, else output
// - clear no-e-clock gives e clock on pin 4
// - one 16-bit write sets assignment and stretch
// - low strobe enable drives pin 3
// - read/write enable drives pin 2
// - data-enable select picks inverted e or enable
`timescale 1ns/10ps
`include "bcpa_map.svh"
module bcpa_port (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // operating mode, stable from reset
  input  wire bcpa_pkg::bcpa_mode_t  i_mode,
  // apb slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [7:0]            i_paddr,
  input  wire logic [31:0]           i_pwdata,
  input  wire logic [3:0]            i_pstrb,
  output logic                       o_pready,
  output logic [31:0]                o_prdata,
  output logic                       o_pslverr,
  // core bus side signals to put on the pins
  input  wire logic [7:0]            i_bus_addr_lo,
  input  wire logic [7:0]            i_bus_data_lo,
  input  wire logic                  i_bus_data_phase,
  input  wire logic                  i_bus_data_oe,
  input  wire logic                  i_e_clock,
  input  wire logic                  i_data_bus_enable,
  input  wire logic                  i_low_strobe,
  input  wire logic                  i_read_write,
  input  wire logic [1:0]            i_pipe_status,
  input  wire logic                  i_clock_gen_test,
  input  wire logic                  i_calibration,
  // low port pins
  input  wire logic [7:0]            i_low_pin,
  output logic [7:0]                 o_low_pin,
  output logic [7:0]                 o_low_pin_oe,
  // control port pins
  input  wire logic [7:0]            i_ctl_pin,
  output logic [7:0]                 o_ctl_pin,
  output logic [7:0]                 o_ctl_pin_oe,
  output logic [7:0]                 o_ctl_pullup,
  // synchronised interrupt pin levels and external e clock in
  output logic [1:0]                 o_irq_level,
  output logic                       o_e_clock_in
);
  import bcpa_pkg::*;

  // mode decode
  // the mode straps are held from before reset release, so these
  // decodes are treated as static and read without synchronising
  logic is_sc, is_special, is_periph, is_exp, is_narrow, is_norm_exp;
  assign is_sc      = (i_mode == BCPA_NORM_SC) || (i_mode == BCPA_SPEC_SC);
  assign is_periph  = (i_mode == BCPA_PERIPH);
  assign is_special = (i_mode == BCPA_SPEC_SC) ||
                      (i_mode == BCPA_SPEC_EXP_NARROW) ||
                      (i_mode == BCPA_SPEC_EXP_WIDE);
  assign is_exp     = !is_sc && !is_periph;
  assign is_narrow  = (i_mode == BCPA_NORM_EXP_NARROW) ||
                      (i_mode == BCPA_SPEC_EXP_NARROW);
  assign is_norm_exp = (i_mode == BCPA_NORM_EXP_NARROW) ||
                       (i_mode == BCPA_NORM_EXP_WIDE);

  // pin synchronisers, first stage read only by second
  logic [7:0] low_s1_q, low_s2_q;     // low port input sync
  logic [7:0] ctl_s1_q, ctl_s2_q;     // control port input sync
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      low_s1_q <= 8'h00;
      low_s2_q <= 8'h00;
      ctl_s1_q <= 8'h00;
      ctl_s2_q <= 8'h00;
    end else begin
      low_s1_q <= i_low_pin;
      low_s2_q <= low_s1_q;
      ctl_s1_q <= i_ctl_pin;
      ctl_s2_q <= ctl_s1_q;
    end
  end

  // registers
  // the low port pair is only reachable in single chip; in the
  // other modes those pins belong to the external bus
  logic [7:0] low_data_q;       // low port output latch
  logic [7:0] low_dir_q;        // low port direction
  logic [7:0] ctl_data_q;       // control port output latch
  logic [7:0] ctl_dir_q;        // control port direction
  logic [7:0] assign_q;         // assignment register
  logic [7:0] mode_reg_q;       // emulate and stretch bits
  logic [7:0] pull_q;           // pull-up control
  logic       first_wr_q;       // no assignment write seen yet
  logic       rst_seen_q;       // mode-dependent reset applied

  // apb decode, two cycle access phase
  // hidden and misaligned offsets fall through with no hit, which
  // the answer process turns into an error and zero read data
  logic       acc, wr;
  logic       hit_low_data, hit_low_dir, hit_ctl_data, hit_ctl_dir;
  logic       hit_assign, hit_mode, hit_pull, hit_any;
  logic [7:0] idx;
  assign acc = i_psel && i_penable && !o_pready;
  assign wr  = acc && i_pwrite;
  assign idx = {2'h0, i_paddr[7:2]};
  always_comb begin
    hit_low_data = 1'b0;
    hit_low_dir  = 1'b0;
    hit_ctl_data = 1'b0;
    hit_ctl_dir  = 1'b0;
    hit_assign   = 1'b0;
    hit_mode     = 1'b0;
    hit_pull     = 1'b0;
    if (i_paddr[1:0] != 2'h0) begin
      // misaligned, unmapped
    end else if (idx == `BCPA_IDX_LOW_DATA) begin
      hit_low_data = is_sc;
    end else if (idx == `BCPA_IDX_LOW_DIR) begin
      hit_low_dir = is_sc;
    end else if (idx == `BCPA_IDX_CTL_DATA) begin
      hit_ctl_data = !is_periph &&
                     !(is_exp && mode_reg_q[`BCPA_EME_BIT]);
    end else if (idx == `BCPA_IDX_CTL_DIR) begin
      hit_ctl_dir = !is_periph &&
                    !(is_exp && mode_reg_q[`BCPA_EME_BIT]);
    end else if (idx == `BCPA_IDX_ASSIGN) begin
      hit_assign = !is_periph;
    end else if (idx == `BCPA_IDX_MODE) begin
      hit_mode = 1'b1;
    end else if (idx == `BCPA_IDX_PULL) begin
      hit_pull = !is_periph;
    end
  end
  assign hit_any = hit_low_data | hit_low_dir | hit_ctl_data |
                   hit_ctl_dir | hit_assign | hit_mode | hit_pull;

  // assignment writes: lane 0 holds assignment, lane 1 the mode byte
  logic       asg_wr, mode_wr;
  logic [7:0] asg_mask;
  logic [7:0] asg_wdata;
  assign asg_wdata = i_pwdata[`BCPA_LANE0_MSB:0];
  // a 16-bit word write at the assignment offset also reaches mode
  assign asg_wr  = wr && hit_assign && i_pstrb[0];
  assign mode_wr = wr && ((hit_mode && i_pstrb[0]) ||
                          (hit_assign && i_pstrb[1]));
  // which assignment bits this write may change: normal modes take
  // the first write only, special modes skip it and take the rest;
  // calibration enable is free, clock test never changes in normal
  always_comb begin
    asg_mask = 8'h00;
    asg_mask[`BCPA_CALIBRATION_ENABLE_BIT] = 1'b1; // calibration: any time
    if (is_special) begin
      if (!first_wr_q) begin
        asg_mask = asg_mask | `BCPA_ONCE_MASK;
      end
    end else if (first_wr_q) begin
      asg_mask = asg_mask | `BCPA_ONCE_MASK;
      asg_mask[`BCPA_CLOCK_GEN_TEST_ENABLE_BIT] = 1'b0;
    end
    // no-e-clock has its own write rules
    asg_mask[`BCPA_NO_E_CLOCK_BIT] = 1'b0;
    if (i_mode == BCPA_NORM_SC) begin
      asg_mask[`BCPA_NO_E_CLOCK_BIT] = first_wr_q;
    end else if (i_mode == BCPA_SPEC_SC) begin
      asg_mask[`BCPA_NO_E_CLOCK_BIT] = 1'b1;
    end
  end

  // mode-dependent reset of assignment, taken after reset release
  // the reset branch loads a constant only; the mode-specific value
  // lands one edge later so the async reset stays constant-only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_seen_q <= 1'b0;
      first_wr_q <= 1'b1;
      assign_q   <= 8'h00;
    end else if (!rst_seen_q) begin
      rst_seen_q <= 1'b1;
      if (i_mode == BCPA_NORM_SC) begin
        assign_q <= `BCPA_RST_NORM_SC;
      end else if (is_norm_exp) begin
        assign_q <= `BCPA_RST_NORM_EXP;
      end else if (is_periph) begin
        assign_q <= `BCPA_RST_PERIPH;
      end else begin
        assign_q <= `BCPA_RST_SPEC;
      end
    end else if (asg_wr) begin
      first_wr_q <= 1'b0;
      assign_q   <= (assign_q & ~asg_mask) | (asg_wdata & asg_mask);
    end
  end

  // port data, direction, mode byte and pull-up writes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      low_data_q <= 8'h00;
      low_dir_q  <= 8'h00;
      ctl_data_q <= 8'h00;
      ctl_dir_q  <= 8'h00;
      mode_reg_q <= 8'h00;
      pull_q     <= `BCPA_PULL_RST;
    end else begin
      if (wr && hit_low_data && i_pstrb[0]) begin
        low_data_q <= i_pwdata[`BCPA_LANE0_MSB:0];
      end
      if (wr && hit_low_dir && i_pstrb[0]) begin
        low_dir_q <= i_pwdata[`BCPA_LANE0_MSB:0];
      end
      if (wr && hit_ctl_data && i_pstrb[0]) begin
        ctl_data_q <= i_pwdata[`BCPA_LANE0_MSB:0];
      end
      if (wr && hit_ctl_dir && i_pstrb[0]) begin
        ctl_dir_q <= i_pwdata[`BCPA_LANE0_MSB:0] & `BCPA_CTL_DIR_MASK;
      end
      if (mode_wr) begin
        // mode byte from lane 1 on a 16-bit assignment write
        mode_reg_q <= (hit_assign ?
                       i_pwdata[`BCPA_LANE1_MSB:`BCPA_LANE1_LSB] :
                       i_pwdata[`BCPA_LANE0_MSB:0]) & `BCPA_MODE_MASK;
      end
      if (wr && hit_pull && i_pstrb[0]) begin
        pull_q <= i_pwdata[`BCPA_LANE0_MSB:0];
      end
    end
  end

  // control port function selection
  // one pass decides, per pin, whether an alternate function owns
  // it; a pin left unowned falls back to its direction bit
  logic [7:0] alt_sel;     // pin driven by alternate output
  logic [7:0] alt_val;     // alternate output value
  logic [7:0] ctl_oe;      // effective output enables
  logic       e_on, pipe_on, cgm_on;
  always_comb begin
    alt_sel = 8'h00;
    alt_val = 8'h00;
    // pin 7: data enable, inverted e, or calibration
    if (is_exp && !assign_q[`BCPA_NO_DATA_ENABLE_BIT]) begin
      alt_sel[7] = 1'b1;
      alt_val[7] = assign_q[`BCPA_DATA_ENABLE_SELECT_BIT] ?
                   !i_e_clock : i_data_bus_enable;
    end else if (assign_q[`BCPA_CALIBRATION_ENABLE_BIT]) begin
      alt_sel[7] = 1'b1;
      alt_val[7] = i_calibration;
    end
    // pins 6 and 5: pipe status, pin 6 clock test
    pipe_on = is_exp && assign_q[`BCPA_PIPE_OUTPUT_ENABLE_BIT];
    cgm_on  = assign_q[`BCPA_CLOCK_GEN_TEST_ENABLE_BIT] && !is_sc && !is_norm_exp;
    if (pipe_on) begin
      alt_sel[6] = 1'b1;
      alt_sel[5] = 1'b1;
      alt_val[6] = i_pipe_status[1];
      alt_val[5] = i_pipe_status[0];
    end else if (cgm_on) begin
      alt_sel[6] = 1'b1;
      alt_val[6] = i_clock_gen_test;
    end
    // pin 4: e clock, stretch must be clear in single chip
    e_on = !assign_q[`BCPA_NO_E_CLOCK_BIT] &&
           !(is_sc && mode_reg_q[`BCPA_E_STRETCH_BIT]);
    if (e_on && !is_periph) begin
      alt_sel[4] = 1'b1;
      alt_val[4] = i_e_clock;
    end
    // pins 3 and 2: strobe and read/write
    if (assign_q[`BCPA_LOW_STROBE_ENABLE_BIT] && !is_sc &&
        (i_mode != BCPA_NORM_EXP_NARROW)) begin
      alt_sel[3] = 1'b1;
      alt_val[3] = i_low_strobe;
    end
    if (assign_q[`BCPA_READ_WRITE_ENABLE_BIT] && !is_sc) begin
      alt_sel[2] = 1'b1;
      alt_val[2] = i_read_write;
    end
    // alternate overrides direction, interrupt pins never drive
    ctl_oe = alt_sel | (ctl_dir_q & ~alt_sel);
    // pin 4 is the e clock input in peripheral mode whatever the
    // no-e-clock bit says, so it must never drive there
    if (is_periph) begin
      ctl_oe[4] = 1'b0;
    end
    ctl_oe[1:0] = 2'h0;
  end

  // pin output flops
  // everything leaving the block is registered so pins change only
  // one edge after the register, mode or alternate that causes them
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ctl_pin    <= 8'h00;
      o_ctl_pin_oe <= 8'h00;
      o_ctl_pullup <= 8'h00;
      o_low_pin    <= 8'h00;
      o_low_pin_oe <= 8'h00;
      o_irq_level  <= 2'h0;
      o_e_clock_in <= 1'b0;
    end else begin
      o_ctl_pin    <= (alt_val & alt_sel) | (ctl_data_q & ~alt_sel);
      o_ctl_pin_oe <= ctl_oe;
      // pull-ups on 7,3,2,1,0 only while input
      o_ctl_pullup <= {8{pull_q[`BCPA_PUPE_BIT]}} & ~ctl_oe &
                      `BCPA_PULL_PINS;
      o_irq_level  <= ctl_s2_q[1:0];
      o_e_clock_in <= is_periph && ctl_s2_q[4];
      if (is_sc) begin
        o_low_pin    <= low_data_q;
        o_low_pin_oe <= low_dir_q;
      end else if (is_narrow || !i_bus_data_phase) begin
        o_low_pin    <= i_bus_addr_lo;
        o_low_pin_oe <= 8'hff;
      end else begin
        o_low_pin    <= i_bus_data_lo;
        o_low_pin_oe <= {8{i_bus_data_oe}};
      end
    end
  end

  // apb answer: one wait state, unmapped gives error and zero data
  // a write lands on the edge that raises pready; the read value is
  // captured on that same edge and held for the single ready cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= acc;
      o_pslverr <= acc && !hit_any;
      o_prdata  <= 32'h0000_0000;
      if (acc && !i_pwrite) begin
        if (hit_low_data) begin
          o_prdata[7:0] <= (low_data_q & low_dir_q) |
                           (low_s2_q & ~low_dir_q);
        end else if (hit_low_dir) begin
          o_prdata[7:0] <= low_dir_q;
        end else if (hit_ctl_data) begin
          o_prdata[7:0] <= (ctl_data_q & ctl_oe) |
                           (ctl_s2_q & ~ctl_oe);
        end else if (hit_ctl_dir) begin
          o_prdata[7:0] <= ctl_dir_q;
        end else if (hit_assign) begin
          o_prdata[15:0] <= {mode_reg_q, assign_q};
        end else if (hit_mode) begin
          o_prdata[7:0] <= mode_reg_q;
        end else if (hit_pull) begin
          o_prdata[7:0] <= pull_q;
        end
      end
    end
  end
endmodule

/* File: tb/bcpa_port_monitor.sv */
// bcpa_port_monitor.sv: assertions on the port block's apb side and pins
// assumes one clock, async high reset, mode held from before reset
`timescale 1ns/10ps
module bcpa_port_monitor (
  // clock, reset, mode
  input wire logic                 i_clk,
  input wire logic                 i_rst,
  input wire bcpa_pkg::bcpa_mode_t i_mode,
  // apb
  input wire logic                 i_psel,
  input wire logic                 i_penable,
  input wire logic                 i_pwrite,
  input wire logic [7:0]           i_paddr,
  input wire logic                 o_pready,
  input wire logic [31:0]          o_prdata,
  input wire logic                 o_pslverr,
  // alternates and pins
  input wire logic [7:0]           i_bus_addr_lo,
  input wire logic                 i_bus_data_phase,
  input wire logic                 i_e_clock,
  input wire logic                 i_clock_gen_test,
  input wire logic [7:0]           o_low_pin,
  input wire logic [7:0]           o_low_pin_oe,
  input wire logic [7:0]           o_ctl_pin,
  input wire logic [7:0]           o_ctl_pin_oe,
  input wire logic [7:0]           o_ctl_pullup
);
  import bcpa_pkg::*;
  logic [1:0] up_q;  // edges since reset, saturating
  logic       ok;    // pins settled after reset
  logic       ne;    // normal expanded mode
  logic       ex;    // any expanded mode
  // count edges after reset release
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  assign ok = (up_q == 2'h3);
  assign ne = i_mode inside {BCPA_NORM_EXP_NARROW, BCPA_NORM_EXP_WIDE};
  assign ex = ne || i_mode inside {BCPA_SPEC_EXP_NARROW, BCPA_SPEC_EXP_WIDE};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ready_wait_a: assert property (
    i_psel && i_penable && !o_pready |=> o_pready) else $error("no pready");
  ready_pulse_a: assert property (
    o_pready |=> !o_pready) else $error("pready too long");
  ready_cause_a: assert property (
    o_pready |-> $past(i_psel && i_penable)) else $error("stray pready");
  misalign_err_a: assert property (
    i_psel && i_penable && !o_pready && i_paddr[1:0] != 2'h0
    |=> o_pslverr) else $error("misaligned not refused");
  err_zero_a: assert property (
    o_pslverr && !i_pwrite |-> o_prdata == 32'h0) else $error("err data");
  irq_input_a: assert property (
    o_ctl_pin_oe[1:0] == 2'h0) else $error("interrupt pin driven");
  pull_inputs_a: assert property (
    (o_ctl_pullup & (o_ctl_pin_oe | 8'h70)) == 8'h00)
    else $error("pull-up on output");
  bus_e_clock_out_a: assert property (
    ok && ne |-> o_ctl_pin_oe[4] && o_ctl_pin[4] == $past(i_e_clock))
    else $error("e clock missing");
  bus_e_clock_in_a: assert property (
    i_mode == BCPA_PERIPH |-> !o_ctl_pin_oe[4]) else $error("e clock out");
  clk_test_a: assert property (
    ok && i_mode == BCPA_PERIPH |-> o_ctl_pin_oe[6] &&
    o_ctl_pin[6] == $past(i_clock_gen_test)) else $error("no test clock");
  low_addr_a: assert property (
    ok && ex && !$past(i_bus_data_phase) |-> o_low_pin_oe == 8'hff &&
    o_low_pin == $past(i_bus_addr_lo)) else $error("low address wrong");
  cover property (o_pready && o_pslverr);
  cover property (o_pready && !o_pslverr && i_pwrite);
  cover property (ok && i_mode == BCPA_PERIPH);
endmodule
bind bcpa_port bcpa_port_monitor bcpa_port_monitor_inst (.i_clk, .i_rst,
  .i_mode, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_pready, .o_prdata,
  .o_pslverr, .i_bus_addr_lo, .i_bus_data_phase, .i_e_clock,
  .i_clock_gen_test, .o_low_pin, .o_low_pin_oe, .o_ctl_pin, .o_ctl_pin_oe,
  .o_ctl_pullup);

/* File: tb/bcpa_pins_model.sv */
// bcpa_pins_model.sv: far side of the pins, memory and board parts
// assumes the bench chooses what outside parts drive
`timescale 1ns/10ps
module bcpa_pins_model (
  // design pin drivers
  input  wire logic [7:0] i_low_out,
  input  wire logic [7:0] i_low_oe,
  input  wire logic [7:0] i_ctl_out,
  input  wire logic [7:0] i_ctl_oe,
  // levels outside parts put on pins the design leaves
  input  wire logic [7:0] i_low_ext,
  input  wire logic [7:0] i_ctl_ext,
  // resolved wire levels
  output logic [7:0]      o_low_wire,
  output logic [7:0]      o_ctl_wire
);
  // memory answers on shared lines when the design lets go
  assign o_low_wire = (i_low_oe & i_low_out) | (~i_low_oe & i_low_ext);
  // interrupt lines always come from the board
  assign o_ctl_wire = (i_ctl_oe & i_ctl_out) | (~i_ctl_oe & i_ctl_ext);
endmodule

/* File: tb/bus_control_port_assignment_bench.sv */
// bus_control_port_assignment_bench.sv: self-checking bench of the port
// assumes package, design, checker and pin model compiled before it
`timescale 1ns/10ps
module bus_control_port_assignment_bench;
  import bcpa_pkg::*;
  logic        i_clk = 1'b0;            // core clock
  logic        i_rst = 1'b1;            // async reset
  bcpa_mode_t  mode = BCPA_NORM_SC;     // strapped mode
  logic        psel = 1'b0;             // apb select
  logic        pen = 1'b0;              // apb enable
  logic        pwr = 1'b0;              // apb direction
  logic [7:0]  paddr = 8'h00;           // apb byte address
  logic [31:0] pwdata = 32'h0;          // apb write data
  logic        pready, pslverr;         // apb answer
  logic [31:0] prdata;                  // apb read data
  logic [31:0] alt = 32'h0;             // random alternate values
  logic        ecl = 1'b0;              // core e clock
  logic [7:0]  low_ext = 8'h00;         // outside drive, low pins
  logic [7:0]  ctl_ext = 8'h00;         // outside drive, control pins
  logic [7:0]  lo_w, ct_w, lo_o, lo_e, ct_o, ct_e; // pins
  logic [7:0]  pu;                      // pull-up enables
  logic [1:0]  irq;                     // synced interrupt levels
  logic        e_in;                    // synced e clock input
  logic [3:0]  pstrb = 4'h0;            // apb byte lanes
  logic [3:0]  lanes = 4'h3;            // lanes of the next write
  logic [31:0] seed = 32'he75dfc2b;     // xorshift state
  int          n_fail = 0;              // mismatches
  int          total_checks = 0;        // comparisons
  int rv [7] = '{8'h90, 8'h00, 8'h00, 8'hd0, 8'h2c, 8'h2c, 8'h2c};
  int fm [7] = '{8'hbf, 8'haf, 8'haf, 8'h00, 8'h12, 8'h02, 8'h02};
  int oe0 [7] = '{8'h00, 8'h90, 8'h90, 8'h40, 8'h10, 8'hfc, 8'hfc};
  int lm [7] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'hff, 8'hef, 8'hef};
  bcpa_port bcpa_port_inst (.i_clk(i_clk), .i_rst(i_rst), .i_mode(mode),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_bus_addr_lo(alt[7:0]),
    .i_bus_data_lo(alt[15:8]), .i_bus_data_phase(alt[16]),
    .i_bus_data_oe(alt[17]), .i_e_clock(ecl),
    .i_data_bus_enable(alt[18]), .i_low_strobe(alt[19]),
    .i_read_write(alt[20]), .i_pipe_status(alt[22:21]),
    .i_clock_gen_test(alt[23]), .i_calibration(alt[24]),
    .i_low_pin(lo_w), .o_low_pin(lo_o), .o_low_pin_oe(lo_e),
    .i_ctl_pin(ct_w), .o_ctl_pin(ct_o), .o_ctl_pin_oe(ct_e),
    .o_ctl_pullup(pu), .o_irq_level(irq), .o_e_clock_in(e_in));
  bcpa_pins_model bcpa_pins_model_inst (.i_low_out(lo_o), .i_low_oe(lo_e),
    .i_ctl_out(ct_o), .i_ctl_oe(ct_e), .i_low_ext(low_ext),
    .i_ctl_ext(ct_e & 8'h00 | ctl_ext), .o_low_wire(lo_w),
    .o_ctl_wire(ct_w));
  // clock generator
  initial forever #4 i_clk = ~i_clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // core alternates move every cycle
  always @(posedge i_clk) begin
    alt <= xs();
    ecl <= ~ecl;
  end
  task automatic tally_and_finish();
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? lanes : 4'h0;
    @(posedge i_clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clk);
    if (n >= 50) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask
  // read, compare masked data and error flag
  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e, input logic ee);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd & m, e);
    chk({31'h0, er}, {31'h0, ee});
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    tally_and_finish();
  end
  // main sequence: every mode in turn
  initial begin
    int k, w, m, asg, mb;
    logic sc;
    logic [31:0] d;
    logic [7:0] cd;
    for (k = 0; k < 7; k++) begin
      i_rst <= 1'b1;
      mode <= bcpa_mode_t'(k);
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_clk);
      sc = (k == 0) || (k == 4);
      chk(ct_e, oe0[k]);
      if (k == 3) rdm(8'h28, 32'hff, 32'h0, 1'b1);
      else rdm(8'h28, 32'hff, rv[k], 1'b0);
      if (k == 3) rdm(8'h24, 32'h0, 32'h0, 1'b1);
      if (sc) rdm(8'h24, 32'hff, 32'h0, 1'b0);
      rdm(8'h04, 32'h0, 32'h0, !sc);
      rdm(8'h29, 32'hffffffff, 32'h0, 1'b1);
      d = xs();
      ctl_ext <= d[31:24];
      repeat (4) @(posedge i_clk);
      chk(irq, d[25:24]);
      chk(e_in, d[28] && k == 3);
      if (sc) begin
        d = xs();
        cd = d[7:0] & 8'hfc;
        ctl_ext <= d[31:24];
        low_ext <= d[23:16];
        wr(8'h24, d);
        wr(8'h20, {24'h0, d[15:8]});
        wr(8'h0c, {24'h0, d[15:8]});
        wr(8'h04, d);
        repeat (4) @(posedge i_clk);
        chk(ct_e & 8'hec, cd & 8'hec);
        chk(ct_o & ct_e & 8'hec, d[15:8] & cd & 8'hec);
        chk(lo_e, d[15:8]);
        chk(lo_o & lo_e, d[7:0] & d[15:8]);
        chk(pu, 8'h8f & ~cd);
        rdm(8'h20, 32'hef, (d[15:8] & cd | d[31:24] & ~cd) & 8'hef, 1'b0);
        rdm(8'h04, 32'hff, d[7:0] & d[15:8] | d[23:16] & ~d[15:8], 1'b0);
      end
      asg = rv[k];
      mb = 0;
      for (w = 0; w < 3 && k != 3; w++) begin
        d = xs();
        lanes = (w == 2) ? 4'h1 : 4'h3;
        wr(8'h28, d);
        m = (w == 0) ? fm[k] : lm[k];
        asg = (asg & ~m) | (d & m);
        if (lanes[1]) mb = d[9:8];
        rdm(8'h28, 32'h3ff, {22'h0, mb[1:0], asg[7:0]}, 1'b0);
        chk(ct_e[7], !sc && !asg[7] || asg[1] || sc && cd[7]);
      end
      lanes = 4'h3;
    end
    tally_and_finish();
  end
endmodule
